//--- hdl/lpc_pkg.sv
// constants for the low-power level and port lock configuration block
// assumes a 100 MHz core clock and byte-wide register accesses
package lpc_pkg;
    // ==========================================================
    // register offsets
    localparam logic [15:0] LVL_ADDR = 16'hec00;
    localparam logic [15:0] CFG2_ADDR = 16'hec01;
    // ==========================================================
    // field positions
    localparam int THR_LSB = 0;
    localparam int THR_W = 3;
    localparam int PER_LSB = 3;
    localparam int PER_W = 5;
    localparam int EXTREF_BIT = 0;
    localparam int LOCK_BIT = 1;
    localparam int IRQ0DIS_BIT = 2;
    // ==========================================================
    // reset values
    localparam logic [7:0] LVL_RESET = 8'h00;
    localparam logic CFG_BIT_RESET = 1'b0;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int LINE_PERIOD_US = 20000;
    localparam int LINE_CYCLES = LINE_PERIOD_US * CLK_MHZ;
    localparam logic [5:0] IRQ_PERIOD_OFFSET = 6'h0a;
    localparam logic [1:0] STROBE_TOGGLES = 2'h3;
endpackage

//--- hdl/lpc_strobe_counter.sv
// counts falling edges of the select strobe pin
// assumes the pin is already synchronous to mclk_i
`timescale 1ns/100ps
module lpc_strobe_counter (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // strobe pin and gating
    input wire logic strobe_i,
    input wire logic enable_i,
    // one-cycle pulse on the third toggle
    output logic three_o
);
    typedef struct packed {
        logic prev;
        logic [1:0] cnt;
        logic hit;
    } lpc_cnt_st_t;

    lpc_cnt_st_t q, d;

    // edge detect and count; counter clears while disabled
    always_comb
    begin
        d = q;
        d.prev = strobe_i;
        d.hit = 1'b0;
        if (!enable_i)
        begin
            d.cnt = 2'h0;
        end
        else if (q.prev && !strobe_i)
        begin
            if (q.cnt == lpc_pkg::STROBE_TOGGLES - 2'h1)
            begin
                d.cnt = 2'h0;
                d.hit = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 2'h1;
            end
        end
    end

    // idle level of the active-low strobe is high
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '{prev: 1'b1, cnt: 2'h0, hit: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign three_o = q.hit;
endmodule

//--- hdl/lpc_config.sv
// low-power level and port lock configuration registers
// assumes the serial engine presents decoded byte accesses, one per pulse
// Contract
// - low three bits pick monitoring threshold
// - interrupt variant period is 0.02s times count+10
// - reference bit chooses internal or external reference
// - unlocked: three strobe toggles switch to spi
// - i2c lock write stops strobe switching
// - any CFG2_ADDR write in spi mode locks port
// - locked choice survives power mode changes
// - disable bit silences interrupt zero in mode two
`timescale 1ns/100ps
module lpc_config #(
    parameter int LINE_CYCLES = lpc_pkg::LINE_CYCLES
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // register access from the serial engine
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // device pins and mode status
    input wire logic select_strobe_pin_i,
    input wire logic second_low_power_mode_i,
    input wire logic lowpower_irq_variant_i,
    input wire logic interrupt_zero_req_i,
    // configuration outputs
    output logic [2:0] lowpower_current_threshold_sel_o,
    output logic external_reference_select_o,
    output logic spi_active_o,
    output logic port_locked_o,
    output logic interrupt_zero_out_o,
    output logic measurement_done_o
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] lvl;
        logic extref;
        logic lock;
        logic irq0dis;
        logic spi;
        logic [7:0] rdata;
        logic rvalid;
        logic izero;
        logic [31:0] tick;
        logic [5:0] line;
        logic done;
    } lpc_state_t;

    lpc_state_t q, d;
    logic strobe_three;
    logic [5:0] line_last;

    // read mux; unmapped and reserved bits read zero
    function automatic logic [7:0] lpc_read(input logic [15:0] a,
                                            input lpc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        if (a == lpc_pkg::LVL_ADDR)
        begin
            v = s.lvl;
        end
        else if (a == lpc_pkg::CFG2_ADDR)
        begin
            v[lpc_pkg::EXTREF_BIT] = s.extref;
            v[lpc_pkg::LOCK_BIT] = s.lock;
            v[lpc_pkg::IRQ0DIS_BIT] = s.irq0dis;
        end
        return v;
    endfunction

    // ==========================================================
    // strobe toggles only count while i2c is active and unlocked
    lpc_strobe_counter u_strobe (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .strobe_i(select_strobe_pin_i),
        .enable_i(!q.lock && !q.spi),
        .three_o(strobe_three)
    );

    // last line index of the interrupt-variant window
    assign line_last = {1'b0, q.lvl[lpc_pkg::PER_LSB +: lpc_pkg::PER_W]}
        + lpc_pkg::IRQ_PERIOD_OFFSET - 6'h01;

    // ==========================================================
    // next state
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        d.rvalid = rd_en_i;
        if (rd_en_i)
        begin
            d.rdata = lpc_read(addr_i, q);
        end
        if (wr_en_i && addr_i == lpc_pkg::LVL_ADDR)
        begin
            d.lvl = wdata_i;
        end
        if (wr_en_i && addr_i == lpc_pkg::CFG2_ADDR)
        begin
            d.extref = wdata_i[lpc_pkg::EXTREF_BIT];
            d.irq0dis = wdata_i[lpc_pkg::IRQ0DIS_BIT];
            // lock is sticky; a zero write never clears it
            if (!q.lock)
            begin
                if (q.spi)
                begin
                    d.lock = 1'b1;
                end
                else if (wdata_i[lpc_pkg::LOCK_BIT])
                begin
                    d.lock = 1'b1;
                end
            end
        end
        // power mode inputs never touch spi or lock
        if (strobe_three && !q.lock && !q.spi)
        begin
            d.spi = 1'b1;
        end
        // in the single-pin variant the host times the window itself
        if (second_low_power_mode_i && lowpower_irq_variant_i)
        begin
            if (q.tick == 32'(LINE_CYCLES - 1))
            begin
                d.tick = 32'h0;
                if (q.line >= line_last)
                begin
                    d.line = 6'h00;
                    d.done = 1'b1;
                end
                else
                begin
                    d.line = q.line + 6'h01;
                end
            end
            else
            begin
                d.tick = q.tick + 32'h1;
            end
        end
        else
        begin
            d.tick = 32'h0;
            d.line = 6'h00;
        end
        // gating adds one cycle of latency to the pin
        d.izero = interrupt_zero_req_i
            && !(second_low_power_mode_i && q.irq0dis);
    end

    // ==========================================================
    // registers; lock only ever cleared here
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
            q.lvl <= lpc_pkg::LVL_RESET;
            q.extref <= lpc_pkg::CFG_BIT_RESET;
            q.lock <= lpc_pkg::CFG_BIT_RESET;
            q.irq0dis <= lpc_pkg::CFG_BIT_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign rvalid_o = q.rvalid;
    assign lowpower_current_threshold_sel_o =
        q.lvl[lpc_pkg::THR_LSB +: lpc_pkg::THR_W];
    assign external_reference_select_o = q.extref;
    assign spi_active_o = q.spi;
    assign port_locked_o = q.lock;
    assign interrupt_zero_out_o = q.izero;
    assign measurement_done_o = q.done;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_lock_sticky: assert property (port_locked_o |=> port_locked_o)
        else $error("port lock dropped");
    a_spi_sticky: assert property (spi_active_o |=> spi_active_o)
        else $error("spi selection dropped");
    a_locked_no_switch: assert property (
        port_locked_o && !spi_active_o |=> !spi_active_o)
        else $error("switched to spi after i2c lock");
    a_spi_write_locks: assert property (
        wr_en_i && addr_i == lpc_pkg::CFG2_ADDR && spi_active_o
        |=> port_locked_o)
        else $error("spi write did not lock port");
    a_i2c_lock_write: assert property (
        wr_en_i && addr_i == lpc_pkg::CFG2_ADDR && !spi_active_o
        && wdata_i[lpc_pkg::LOCK_BIT] |=> port_locked_o)
        else $error("lock write not taken");
    a_strobe_switch: assert property (
        strobe_three && !port_locked_o && !spi_active_o
        |=> spi_active_o)
        else $error("third toggle did not select spi");
    a_izero_gated: assert property (
        second_low_power_mode_i && q.irq0dis |=> !interrupt_zero_out_o)
        else $error("interrupt zero not disabled");
    a_izero_pass: assert property (
        !second_low_power_mode_i && interrupt_zero_req_i
        |=> interrupt_zero_out_o)
        else $error("interrupt zero not passed");
    a_extref_write: assert property (
        wr_en_i && addr_i == lpc_pkg::CFG2_ADDR
        |=> external_reference_select_o
            == $past(wdata_i[lpc_pkg::EXTREF_BIT]))
        else $error("reference select not written");
    a_thr_write: assert property (
        wr_en_i && addr_i == lpc_pkg::LVL_ADDR
        |=> lowpower_current_threshold_sel_o == $past(wdata_i[2:0]))
        else $error("threshold select not written");
    // the single-pin variant must never raise a window pulse
    a_done_window: assert property (
        measurement_done_o |-> $past(second_low_power_mode_i)
            && $past(lowpower_irq_variant_i))
        else $error("measurement done outside interrupt variant");
endmodule

//--- dv/lpc_host_model.sv
// host side model: drives the select strobe pin
// assumes go_i is a one-cycle pulse synchronous to mclk_i
`timescale 1ns/100ps
module lpc_host_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // request and pin
    input wire logic go_i,
    output logic strobe_o
);
    // ==========
    // phase counter; pin idles high, two cycles per level except one for the last low
    logic [3:0] ph_q;
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ph_q <= 4'h0;
        else if (go_i)
            ph_q <= 4'hb;
        else if (ph_q != 4'h0)
            ph_q <= ph_q - 4'h1;
    end
    // three falling edges, spaced wider than the minimum
    assign strobe_o = (ph_q == 4'h0) | ph_q[1];
endmodule

//--- dv/lpc_config_tb.sv
// self-checking bench for the configuration registers
// assumes lpc_config and lpc_host_model are compiled first
`timescale 1ns/100ps
module lowpower_and_port_lock_config_tb_top;
    // ==========
    // stimulus and observation
    logic mclk_i, rst_b_i, wr_en, rd_en, pin, mode2, irqv, req, go;
    logic rvalid, locked, spi, ext, izo, done;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] thr;
    int fail_count, n_tests, cyc, n;
    // short line period keeps windows to tens of cycles
    lpc_config #(.LINE_CYCLES(4)) lpc_config_i (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
        .rdata_o(rdata), .rvalid_o(rvalid),
        .select_strobe_pin_i(pin), .second_low_power_mode_i(mode2),
        .lowpower_irq_variant_i(irqv), .interrupt_zero_req_i(req),
        .lowpower_current_threshold_sel_o(thr),
        .external_reference_select_o(ext), .spi_active_o(spi),
        .port_locked_o(locked), .interrupt_zero_out_o(izo),
        .measurement_done_o(done));
    lpc_host_model lpc_host_model_i (.mclk_i(mclk_i),
        .rst_b_i(rst_b_i), .go_i(go), .strobe_o(pin));
    // ==========
    // clock and hang guard
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            end_sim();
        end
    end
    // ==========
    // tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // falling edges are the settled points where outputs are looked at
    task tick(input int k);
        repeat (k) @(negedge mclk_i);
    endtask
    // launched at one rising edge, taken by the design at the next
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_i);
        wr_en <= 1'b0;
        tick(1);
    endtask
    // read answer is registered one cycle after the strobe
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk_i);
        rd_en <= 1'b0;
        tick(1);
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, e);
    endtask
    task wait_done(input int lim);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (done !== 1'b1 && n < lim);
    endtask
    task do_reset();
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        tick(1);
    endtask
    // one-cycle go pulse; the model needs eleven cycles for three edges
    task strobe3();
        @(posedge mclk_i);
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        tick(14);
    endtask
    task end_sim();
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        {wr_en, rd_en, mode2, irqv, req, go} = 6'h00;
        {addr, wdata} = 24'h000000;
        {fail_count, n_tests, cyc} = 0;
        rst_b_i = 1'b0;
        do_reset();
        rd(lpc_pkg::LVL_ADDR, 8'h00);
        rd(lpc_pkg::CFG2_ADDR, 8'h00);
        wr(lpc_pkg::LVL_ADDR, 8'h5d);
        chk({5'h0, thr}, 8'h05);
        rd(lpc_pkg::LVL_ADDR, 8'h5d);
        wr(16'hec02, 8'hff);
        rd(lpc_pkg::LVL_ADDR, 8'h5d);
        rd(16'hec02, 8'h00);
        @(posedge mclk_i);
        mode2 <= 1'b1;
        irqv <= 1'b1;
        wait_done(300);
        wait_done(300);
        chk(n[7:0], 8'h54);
        @(posedge mclk_i);
        irqv <= 1'b0;
        req <= 1'b1;
        wait_done(200);
        chk(n[7:0], 8'hc8);
        wr(lpc_pkg::CFG2_ADDR, 8'h04);
        tick(2);
        chk({7'h0, izo}, 8'h00);
        @(posedge mclk_i);
        mode2 <= 1'b0;
        tick(2);
        chk({7'h0, izo}, 8'h01);
        wr(lpc_pkg::CFG2_ADDR, 8'h05);
        chk({6'h0, locked, ext}, 8'h01);
        rd(lpc_pkg::CFG2_ADDR, 8'h05);
        strobe3();
        chk({7'h0, spi}, 8'h01);
        wr(lpc_pkg::CFG2_ADDR, 8'h00);
        chk({6'h0, locked, ext}, 8'h02);
        wr(lpc_pkg::CFG2_ADDR, 8'h00);
        rd(lpc_pkg::CFG2_ADDR, 8'h02);
        @(posedge mclk_i);
        mode2 <= 1'b1;
        tick(3);
        @(posedge mclk_i);
        mode2 <= 1'b0;
        tick(3);
        chk({6'h0, locked, spi}, 8'h03);
        do_reset();
        chk({6'h0, locked, spi}, 8'h00);
        wr(lpc_pkg::CFG2_ADDR, 8'h02);
        strobe3();
        chk({6'h0, locked, spi}, 8'h02);
        end_sim();
    end
endmodule
